/* File: common/srmc_pkg.sv */
package srmc_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned WORDS  = 8192;

  // ----------------------------------------------------------------
  // timing, fast grade default, in ns and in 8 ns cycles
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CYCLE_NS      = 70;  // least read or write cycle
  localparam int unsigned WPULSE_NS     = 50;  // least write strobe low time
  localparam int unsigned SEL_WR_NS     = 65;  // least select time before write end
  localparam int unsigned ACCESS_NS     = 70;  // address to data valid
  localparam int unsigned DIS_NS        = 25;  // release time after strobe or select
  // least times round up to whole cycles
  localparam int unsigned CYCLE_CYC  = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPULSE_CYC = (WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEL_WR_CYC = (SEL_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIS_CYC    = (DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W      = 8;

  // ----------------------------------------------------------------
  // pin bundle toward the memory and values after reset
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic              select_primary_n;
    logic              select_secondary;
    logic              output_gate_n;
    logic              write_strobe_n;
    logic [DATA_W-1:0] data_out;
    logic              data_oe_n;      // low while the controller drives the lines
  } srmc_pins_t;

  localparam srmc_pins_t PINS_RST = '{
    word_address:     13'h0000,
    select_primary_n: 1'b1,
    select_secondary: 1'b0,
    output_gate_n:    1'b1,
    write_strobe_n:   1'b1,
    data_out:         8'h00,
    data_oe_n:        1'b1
  };

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_END,
    ST_RECOVER
  } srmc_state_t;

endpackage : srmc_pkg

/* File: design/srmc_timer.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// down counter that marks when a loaded interval has elapsed
// ------------------------------------------------------------------
module srmc_timer
  import srmc_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } srmc_tmr_t;

  srmc_tmr_t st_q;
  srmc_tmr_t st_d;

  // load wins over counting so a fresh interval is never shortened
  always_comb begin
    st_d = st_q;
    if (load_i) begin
      st_d.cnt = count_i;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // done looks only at the count; gating it with load would close a
  // combinational loop through a caller that reloads on done
  assign done_o = (st_q.cnt == '0);

endmodule : srmc_timer

/* File: design/srmc_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - the host keeps each read and write cycle at least 70 ns (fast) or 100 ns (slow).
// - the host holds write_strobe_n low at least 50 ns (fast) or 70 ns (slow).
// - the host keeps the memory selected at least 65 ns (fast) or 90 ns (slow) before write end.
// - a write is the overlap of strobe and both selects, ended by whichever the host picks.
// - with selects and gate held and strobe high, reads follow by changing only the address.
module srmc_ctrl
  import srmc_pkg::*;
#(
  parameter int unsigned CYCLE_C  = CYCLE_CYC,
  parameter int unsigned WPULSE_C = WPULSE_CYC,
  parameter int unsigned SELWR_C  = SEL_WR_CYC,
  parameter int unsigned ACCESS_C = ACCESS_CYC,
  parameter int unsigned DIS_C    = DIS_CYC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // user request port
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  // memory pins
  output logic [ADDR_W-1:0]      word_address_o,
  output logic                   select_primary_n_o,
  output logic                   select_secondary_o,
  output logic                   output_gate_n_o,
  output logic                   write_strobe_n_o,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic                   data_lines_oe_n_o,
  input  wire logic [DATA_W-1:0] data_lines_i
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    srmc_state_t       state;
    srmc_pins_t        pins;
    logic [DATA_W-1:0] sync1;
    logic [DATA_W-1:0] sync2;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_rdata;
    logic              cyc_ok;    // least cycle time met since last address change
    logic              sel_ok;    // least select time met before write end
  } srmc_st_t;

  srmc_st_t st_q;
  srmc_st_t st_d;

  logic             tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic             tmr_done;
  logic             ctmr_load;
  logic             ctmr_done;
  logic             stmr_done;

  // converts a cycle count parameter to the timer width
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction : cyc

  // ----------------------------------------------------------------
  // timers: phase timer, cycle timer, select-to-write-end timer
  // ----------------------------------------------------------------
  srmc_timer #(.W(CNT_W)) u_phase (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .load_i    (tmr_load),
    .count_i   (tmr_count),
    .done_o    (tmr_done)
  );

  srmc_timer #(.W(CNT_W)) u_cycle (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .load_i    (ctmr_load),
    .count_i   (cyc(CYCLE_C - 1)),
    .done_o    (ctmr_done)
  );

  // reloaded with the cycle timer while the selects are active: each new read or write and each chained read
  srmc_timer #(.W(CNT_W)) u_select (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .load_i    (ctmr_load && st_d.pins.select_secondary),
    .count_i   (cyc(SELWR_C - 1)),
    .done_o    (stmr_done)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // strobe-timed writes: selects and address first, strobe pulse, data
  // held until strobe rises, then selects drop; reads are address-timed
  // with gate low and strobe high so back-to-back reads change only address
  always_comb begin
    st_d       = st_q;
    tmr_load   = 1'b0;
    tmr_count  = '0;
    ctmr_load  = 1'b0;
    st_d.sync1 = data_lines_i;
    st_d.sync2 = st_q.sync1;
    st_d.rsp_valid = 1'b0;
    st_d.cyc_ok = st_q.cyc_ok | ctmr_done;
    st_d.sel_ok = st_q.sel_ok | stmr_done;
    case (st_q.state)
      ST_IDLE: begin
        if (req_valid_i) begin
          // select, new address: a fresh cycle starts here
          st_d.pins.select_primary_n = 1'b0;
          st_d.pins.select_secondary = 1'b1;
          st_d.pins.word_address     = req_addr_i;
          st_d.cyc_ok                = 1'b0;
          st_d.sel_ok                = 1'b0;
          ctmr_load                  = 1'b1;
          if (req_write_i) begin
            st_d.pins.output_gate_n = 1'b1;
            st_d.pins.data_out      = req_wdata_i;
            st_d.pins.data_oe_n     = 1'b0;
            st_d.state              = ST_WR_SETUP;
          end else begin
            st_d.pins.output_gate_n = 1'b0;
            st_d.pins.data_oe_n     = 1'b1;
            tmr_load                = 1'b1;
            tmr_count               = cyc(ACCESS_C + 2);          // plus two for sync
            st_d.state              = ST_RD;
          end
        end
      end
      ST_RD: begin
        // lines float after address change until access time, then sample
        if (tmr_done && st_q.cyc_ok) begin
          st_d.rsp_valid = 1'b1;
          st_d.rsp_rdata = st_q.sync2;
          if (req_valid_i && !req_write_i) begin
            st_d.pins.word_address = req_addr_i;
            st_d.cyc_ok            = 1'b0;
            ctmr_load              = 1'b1;
            tmr_load               = 1'b1;
            tmr_count              = cyc(ACCESS_C + 2);
          end else begin
            // drop gate and selects together; this ends the read
            st_d.pins.output_gate_n    = 1'b1;
            st_d.pins.select_primary_n = 1'b1;
            st_d.pins.select_secondary = 1'b0;
            tmr_load                   = 1'b1;
            tmr_count                  = cyc(DIS_C);
            st_d.state                 = ST_RECOVER;
          end
        end
      end
      ST_WR_SETUP: begin
        // gate already high; strobe low makes the lines inputs
        st_d.pins.write_strobe_n = 1'b0;
        tmr_load                 = 1'b1;
        tmr_count                = cyc(WPULSE_C - 1);
        st_d.state               = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        // end the overlap with the strobe, data still driven
        if (tmr_done && st_q.sel_ok && st_q.cyc_ok) begin
          st_d.pins.write_strobe_n = 1'b1;
          st_d.state               = ST_WR_END;
        end
      end
      ST_WR_END: begin
        // data held one cycle past strobe rise, then release and deselect
        st_d.pins.data_oe_n        = 1'b1;
        st_d.pins.select_primary_n = 1'b1;
        st_d.pins.select_secondary = 1'b0;
        st_d.rsp_valid             = 1'b1;
        tmr_load                   = 1'b1;
        tmr_count                  = cyc(DIS_C);
        st_d.state                 = ST_RECOVER;
      end
      ST_RECOVER: begin
        // wait for memory to release the lines before next cycle
        if (tmr_done) begin
          st_d.state = ST_IDLE;
        end
      end
      default: begin
        st_d.state = ST_IDLE;
        st_d.pins  = PINS_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '{state: ST_IDLE, pins: PINS_RST, sync1: '0, sync2: '0,
                rsp_valid: 1'b0, rsp_rdata: '0, cyc_ok: 1'b0, sel_ok: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a request is taken in idle, or as the next read during a read
  assign req_ready_o = (st_q.state == ST_IDLE) ||
                       (st_q.state == ST_RD && tmr_done && st_q.cyc_ok && !req_write_i);
  assign rsp_valid_o        = st_q.rsp_valid;
  assign rsp_rdata_o        = st_q.rsp_rdata;
  assign word_address_o     = st_q.pins.word_address;
  assign select_primary_n_o = st_q.pins.select_primary_n;
  assign select_secondary_o = st_q.pins.select_secondary;
  assign output_gate_n_o    = st_q.pins.output_gate_n;
  assign write_strobe_n_o   = st_q.pins.write_strobe_n;
  assign data_lines_o       = st_q.pins.data_out;
  assign data_lines_oe_n_o  = st_q.pins.data_oe_n;

endmodule : srmc_ctrl

/* File: test/srmc_ctrl_assertions.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// pin protocol checks
// ------------------------------------------------------------------
module srmc_ctrl_assertions
  import srmc_pkg::*;
#(
  parameter int unsigned SELWR_C = SEL_WR_CYC
) (
  input wire logic              ref_clk_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] word_address_o,
  input wire logic              select_primary_n_o,
  input wire logic              select_secondary_o,
  input wire logic              output_gate_n_o,
  input wire logic              write_strobe_n_o,
  input wire logic [DATA_W-1:0] data_lines_o,
  input wire logic              data_lines_oe_n_o
);
  logic       sel;
  logic [7:0] sel_cnt_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  assign sel = !select_primary_n_o && select_secondary_o;
  // cycles selected; saturates so a long read chain cannot wrap
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sel_cnt_q <= 8'h00;
    else if (!sel) sel_cnt_q <= 8'h00;
    else if (sel_cnt_q != 8'hFF) sel_cnt_q <= sel_cnt_q + 8'h01;
  end
  property p_wr_pulse; $fell(write_strobe_n_o) |-> !write_strobe_n_o [*7]; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("strobe pulse short");
  property p_sel_wr; $rose(write_strobe_n_o) |-> sel_cnt_q >= SELWR_C; endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("select short before write end");
  property p_cycle; $rose(sel) |=> sel [*8]; endproperty
  a_cycle: assert property (p_cycle) else $error("select cycle short");
  property p_wr_frame; !write_strobe_n_o |-> sel && !data_lines_oe_n_o; endproperty
  a_wr_frame: assert property (p_wr_frame) else $error("strobe outside frame");
  property p_no_fight; !data_lines_oe_n_o |-> output_gate_n_o; endproperty
  a_no_fight: assert property (p_no_fight) else $error("lines driven with gate low");
  property p_hold; $rose(write_strobe_n_o) |-> !data_lines_oe_n_o && $stable(data_lines_o); endproperty
  a_hold: assert property (p_hold) else $error("write data not held");
  property p_gate; !output_gate_n_o |-> sel && write_strobe_n_o; endproperty
  a_gate: assert property (p_gate) else $error("gate low outside read");
  property p_wr_addr; !write_strobe_n_o |-> $stable(word_address_o); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("address moved in write");
  property p_rd_addr;
    $changed(word_address_o) && !output_gate_n_o |=> $stable(word_address_o) [*7];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address held short");
endmodule : srmc_ctrl_assertions

bind srmc_ctrl srmc_ctrl_assertions #(.SELWR_C(SELWR_C)) u_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .word_address_o(word_address_o),
  .select_primary_n_o(select_primary_n_o), .select_secondary_o(select_secondary_o),
  .output_gate_n_o(output_gate_n_o), .write_strobe_n_o(write_strobe_n_o),
  .data_lines_o(data_lines_o), .data_lines_oe_n_o(data_lines_oe_n_o));

/* File: test/srmc_sram_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------------
// behavioural memory; also resolves the shared lines
// ------------------------------------------------------------------
module srmc_sram_model
  import srmc_pkg::*;
#(
  parameter int unsigned ACC_NS = ACCESS_NS
) (
  input  wire logic              ref_clk_i,
  input  wire logic [ADDR_W-1:0] word_address_i,
  input  wire logic              select_primary_n_i,
  input  wire logic              select_secondary_i,
  input  wire logic              output_gate_n_i,
  input  wire logic              write_strobe_n_i,
  input  wire logic [DATA_W-1:0] host_data_i,
  input  wire logic              host_oe_n_i,
  output logic [DATA_W-1:0]      data_lines_o
);
  logic [DATA_W-1:0] mem_q [WORDS];
  logic [DATA_W-1:0] last_q;
  logic              sel;
  logic              wr_act;
  logic              drive;
  logic              valid_q = 1'b0;
  int unsigned       gen_q   = 0;
  assign sel    = !select_primary_n_i && select_secondary_i;
  assign wr_act = sel && !write_strobe_n_i;
  assign drive  = sel && write_strobe_n_i && !output_gate_n_i && valid_q;
  // every new address or selection restarts the access time
  always @(word_address_i or sel) begin
    valid_q = 1'b0;
    gen_q = gen_q + 1;
    fork
      automatic int unsigned g = gen_q;
      begin
        #(ACC_NS);
        if (g == gen_q) valid_q = 1'b1;
      end
    join_none
  end
  // word taken when the first framing signal leaves its active state
  always @(negedge wr_act) mem_q[word_address_i] = data_lines_o;
  // undriven lines show the inverse of the last value, never a stale word
  assign data_lines_o = !host_oe_n_i ? host_data_i : drive ? mem_q[word_address_i] : ~last_q;
  always_ff @(posedge ref_clk_i) last_q <= data_lines_o;
endmodule : srmc_sram_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench
  import srmc_pkg::*;
;
  logic              ref_clk_i, arst_n_i, req_valid_i, req_write_i;
  logic              req_ready_o, rsp_valid_o, sp_n, ss, og_n, we_n, oe_n;
  logic [ADDR_W-1:0] req_addr_i, addr;
  logic [DATA_W-1:0] req_wdata_i, rsp_rdata_o, dout, lines;
  logic [DATA_W-1:0] rsp_q [$];
  int                err_count, checks_done, cyc;
  srmc_ctrl DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .word_address_o(addr), .select_primary_n_o(sp_n), .select_secondary_o(ss),
    .output_gate_n_o(og_n), .write_strobe_n_o(we_n), .data_lines_o(dout),
    .data_lines_oe_n_o(oe_n), .data_lines_i(lines));
  srmc_sram_model u_mem (.ref_clk_i(ref_clk_i), .word_address_i(addr),
    .select_primary_n_i(sp_n), .select_secondary_i(ss), .output_gate_n_i(og_n),
    .write_strobe_n_i(we_n), .host_data_i(dout), .host_oe_n_i(oe_n), .data_lines_o(lines));
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // responses queue up so chained reads need no exact timing
  always @(posedge ref_clk_i) if (rsp_valid_o === 1'b1) rsp_q.push_back(rsp_rdata_o);
  // hang guard, far above the expected few hundred cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] pat(input logic [12:0] a, input logic [7:0] s);
    return a[7:0] ^ {3'h0, a[12:8]} ^ s;
  endfunction : pat
  // request held until taken; valid stays up for chaining
  task automatic issue(input logic w, input logic [12:0] a, input logic [7:0] d);
    int n;
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 300);
    #1;
  endtask : issue
  task automatic drain(input int n);
    req_valid_i = 1'b0;
    for (int k = 0; k < 500 && rsp_q.size() < n; k++) @(posedge ref_clk_i);
    #1;
    check("responses", 16'(rsp_q.size()), 16'(n));
  endtask : drain
  task automatic t_pins;
    check("sel_p_n", sp_n, 16'h0001);
    check("sel_s", ss, 16'h0000);
    check("gate_n", og_n, 16'h0001);
    check("strobe_n", we_n, 16'h0001);
    check("oe_n", oe_n, 16'h0001);
  endtask : t_pins
  logic [12:0] al [4] = '{13'h0000, 13'h0001, 13'h1FFF, 13'h0AAA};
  task automatic t_single;
    for (int i = 0; i < 4; i++) begin
      issue(1'b1, al[i], pat(al[i], 8'h5A));
      drain(1);
      rsp_q.delete();
    end
    for (int i = 0; i < 4; i++) begin
      issue(1'b0, al[i], 8'h00);
      drain(1);
      check("rdata", rsp_q[0], pat(al[i], 8'h5A));
      rsp_q.delete();
    end
  endtask : t_single
  task automatic t_chain;
    for (int i = 3; i >= 0; i--) issue(1'b0, al[i], 8'h00);
    drain(4);
    for (int i = 0; i < 4; i++) check("chain", rsp_q[i], pat(al[3-i], 8'h5A));
    rsp_q.delete();
  endtask : t_chain
  // write right behind a read to the same word: read must close first
  task automatic t_turn;
    issue(1'b0, 13'h0AAA, 8'h00);
    issue(1'b1, 13'h0AAA, 8'h3C);
    drain(2);
    check("old", rsp_q[0], pat(13'h0AAA, 8'h5A));
    rsp_q.delete();
    issue(1'b0, 13'h0AAA, 8'h00);
    drain(1);
    check("new", rsp_q[0], 8'h3C);
    rsp_q.delete();
  endtask : t_turn
  task automatic t_mid_reset;
    issue(1'b1, 13'h0005, 8'hC3);
    req_valid_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1 arst_n_i = 1'b0;
    #1 t_pins();
    @(posedge ref_clk_i);
    #1 arst_n_i = 1'b1;
    rsp_q.delete();
    issue(1'b0, 13'h1FFF, 8'h00);
    drain(1);
    check("after", rsp_q[0], pat(13'h1FFF, 8'h5A));
  endtask : t_mid_reset
  initial begin
    arst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 13'h0000;
    req_wdata_i = 8'h00;
    repeat (3) @(posedge ref_clk_i);
    t_pins();
    #1 arst_n_i = 1'b1;
    t_single();
    t_chain();
    t_turn();
    t_mid_reset();
    give_verdict();
  end
endmodule : testbench
